// ### core/pwmofl_top.sv
// PWM output stage: polarity, pin enable, fault lockout and update lockout
//
// Added by the designer: the placing of the registers and the APB slave port.
`include "pwmofl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pwmofl_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  pwm_raw,
  input  wire logic        period_start,
  input  wire logic        fault_in_n,
  input  wire logic        breakpoint,
  input  wire logic        high_side_polarity,
  input  wire logic        low_side_polarity,
  input  wire logic        reset_pin_function_select,
  input  wire logic [5:0]  port_latch,
  input  wire logic [5:0]  pin_direction_latch,
  output var  logic [5:0]  pin_out,
  output var  logic [5:0]  pin_oe,
  output var  logic [47:0] active_duty,
  output var  logic [11:0] active_period,
  output var  logic        irq
);

  pwmofl_pkg::pwmofl_state_t st;      // Current state
  pwmofl_pkg::pwmofl_state_t next_st; // Next state

  logic       wr_acc;       // Write in access phase
  logic       rd_setup;     // Read in setup phase
  logic       fault_active; // Enabled, synchronised fault
  logic       brk_active;   // Enabled breakpoint fault
  logic       force_off;    // Pins forced inactive
  logic [5:0] pol;          // Per-pin inversion
  logic [5:0] pair_on;      // Per-pin PWM ownership
  logic [5:0] drive;        // Active-high drive before polarity

  // Address decode shared by read mux and error answer
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `PWMOFL_OFS_FCFG) || (a == `PWMOFL_OFS_CTRL0) ||
              (a == `PWMOFL_OFS_CTRL1) || (a == `PWMOFL_OFS_STATE) ||
              (a >= `PWMOFL_OFS_DUTY0 && a <= `PWMOFL_OFS_PERIOD && a[1:0] == 2'h0) ||
              (a == `PWMOFL_OFS_IRQ_ST) || (a == `PWMOFL_OFS_IRQ_MASK);
  endfunction

  // Buffer slot from a byte address in the duty/period window
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - `PWMOFL_OFS_DUTY0;
    slot_of = d[4:2];
  endfunction

  // Zero-wait slave; read data is captured in the setup cycle
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign wr_acc  = psel & penable & pwrite & addr_ok(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;

  // Pin fault after synchronisation, breakpoint taken as is; no software step needed
  assign fault_active = st.cfg_en & st.fault_lvl;
  assign brk_active   = st.cfg_brk & breakpoint;
  assign force_off    = fault_active | brk_active | st.fault_block;

  // Odd pins are high side, even pins low side; zero means active-high
  assign pol = {high_side_polarity, low_side_polarity,
                high_side_polarity, low_side_polarity,
                high_side_polarity, low_side_polarity};

  // Pair p owns its pins when the field exceeds p; 1xx enables all
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      pair_on[2*p]   = (st.pin_en > 3'(p)) | st.pin_en[2];
      pair_on[2*p+1] = (st.pin_en > 3'(p)) | st.pin_en[2];
    end
  end

  // Force inactive ahead of polarity so the inversion stays the last stage
  assign drive = force_off ? 6'h00 : pwm_raw;

  // Next-state logic for the whole block
  always_comb
  begin
    next_st = st;

    // Three-stage sync; a change counts when stages two and three agree
    next_st.fsync = {st.fsync[1:0], fault_in_n};
    if (st.fsync[1] == st.fsync[2])
    begin
      next_st.fault_lvl = ~st.fsync[2];
    end

    // Strap applied once after release, never inside the async reset
    if (!st.strap_done)
    begin
      next_st.strap_done = 1'b1;
      next_st.pin_en = reset_pin_function_select ? `PWMOFL_PIN_EN_OFF
                                                 : `PWMOFL_PIN_EN_ALL;
    end

    // Register writes
    if (wr_acc)
    begin
      unique case (paddr)
        `PWMOFL_OFS_FCFG:
        begin
          next_st.cfg_brk  = pwdata[`PWMOFL_FCFG_BRK];
          next_st.cfg_mode = pwdata[`PWMOFL_FCFG_MODE];
          next_st.cfg_en   = pwdata[`PWMOFL_FCFG_EN];
          // Writing zero clears status only once the pin is high
          if (!pwdata[`PWMOFL_FCFG_STAT] && !st.fault_lvl)
          begin
            next_st.fault_stat = 1'b0;
          end
        end
        `PWMOFL_OFS_CTRL0:
        begin
          next_st.pin_en = pwdata[`PWMOFL_CTRL0_EN_MSB:`PWMOFL_CTRL0_EN_LSB];
        end
        `PWMOFL_OFS_CTRL1:
        begin
          next_st.lockout = pwdata[`PWMOFL_CTRL1_LOCK];
        end
        `PWMOFL_OFS_IRQ_ST:
        begin
          // Write one to clear; set below still wins
          next_st.irq_st = st.irq_st & ~pwdata[1:0];
        end
        `PWMOFL_OFS_IRQ_MASK:
        begin
          next_st.irq_mask = pwdata[1:0];
        end
        `PWMOFL_OFS_STATE:
        begin
          // Read-only view, writes ignored
        end
        default:
        begin
          // Duty and period buffers
          next_st.buf_word[slot_of(paddr)] = pwdata[`PWMOFL_BUF_W-1:0];
        end
      endcase
    end

    // Cycle mode: status self-clears at period start once pin is high
    if (st.cfg_mode && period_start && !st.fault_lvl)
    begin
      next_st.fault_stat = 1'b0;
    end

    // Status set has priority over any clear
    if (fault_active)
    begin
      next_st.fault_stat = 1'b1;
    end

    // Blocking holds until a period start that meets the mode's condition
    if (fault_active || brk_active)
    begin
      next_st.fault_block = 1'b1;
    end
    else if (period_start && st.fault_block)
    begin
      if (st.cfg_mode || !st.fault_stat || !st.cfg_en)
      begin
        next_st.fault_block = 1'b0;
      end
    end

    // Unlocked buffers flow to the active words; the unlock cycle loads all
    if (!st.lockout)
    begin
      next_st.act_word = st.buf_word;
    end

    // Sticky interrupt events on rising fault sources
    next_st.fault_prev = fault_active;
    next_st.brk_prev   = brk_active;
    if (fault_active && !st.fault_prev)
    begin
      next_st.irq_st[`PWMOFL_IRQ_FAULT] = 1'b1;
    end
    if (brk_active && !st.brk_prev)
    begin
      next_st.irq_st[`PWMOFL_IRQ_BRK] = 1'b1;
    end
    next_st.irq = |(next_st.irq_st & next_st.irq_mask);

    // Pin stage: PWM owns enabled pairs, port controls the rest
    for (int i = 0; i < 6; i++)
    begin
      if (pair_on[i])
      begin
        next_st.pin_out[i] = drive[i] ^ pol[i];
        next_st.pin_oe[i]  = 1'b1;
      end
      else
      begin
        next_st.pin_out[i] = port_latch[i];
        next_st.pin_oe[i]  = pin_direction_latch[i];
      end
    end

    // Read mux, captured during the setup cycle
    if (rd_setup)
    begin
      next_st.prdata = 32'h0000_0000;
      unique case (paddr)
        `PWMOFL_OFS_FCFG:
        begin
          next_st.prdata[`PWMOFL_FCFG_BRK]  = st.cfg_brk;
          next_st.prdata[`PWMOFL_FCFG_STAT] = st.fault_stat;
          next_st.prdata[`PWMOFL_FCFG_MODE] = st.cfg_mode;
          next_st.prdata[`PWMOFL_FCFG_EN]   = st.cfg_en;
        end
        `PWMOFL_OFS_CTRL0:
        begin
          next_st.prdata[`PWMOFL_CTRL0_EN_MSB:`PWMOFL_CTRL0_EN_LSB] = st.pin_en;
        end
        `PWMOFL_OFS_CTRL1:
        begin
          next_st.prdata[`PWMOFL_CTRL1_LOCK] = st.lockout;
        end
        `PWMOFL_OFS_STATE:
        begin
          next_st.prdata[2:0] = {force_off, brk_active, st.fault_lvl};
        end
        `PWMOFL_OFS_IRQ_ST:
        begin
          next_st.prdata[1:0] = st.irq_st;
        end
        `PWMOFL_OFS_IRQ_MASK:
        begin
          next_st.prdata[1:0] = st.irq_mask;
        end
        default:
        begin
          // Buffers read back; unmapped addresses read zero
          if (addr_ok(paddr))
          begin
            next_st.prdata[`PWMOFL_BUF_W-1:0] = st.buf_word[slot_of(paddr)];
          end
        end
      endcase
    end
  end

  // State register; constants only under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st             <= '0;
      st.fsync       <= `PWMOFL_SYNC_IDLE;
      st.pin_en      <= `PWMOFL_PIN_EN_OFF;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign prdata        = st.prdata;
  assign pin_out       = st.pin_out;
  assign pin_oe        = st.pin_oe;
  assign irq           = st.irq;
  assign active_duty   = {st.act_word[3], st.act_word[2], st.act_word[1], st.act_word[0]};
  assign active_period = st.act_word[`PWMOFL_PERIOD_SLOT];

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Fault as the output logic sees it, after filtering and enable
  sequence s_fault_seen;
    fault_active;
  endsequence

  // Filtered pin released in the cycle of a period start
  sequence s_pin_high_at_start;
    !st.fault_lvl && period_start;
  endsequence

  // Stages two and three agree low
  sequence s_sync_low;
    st.fsync[2:1] == 2'b00;
  endsequence

  // Stages two and three agree high
  sequence s_sync_high;
    st.fsync[2:1] == 2'b11;
  endsequence

  // Only meaningful with all pairs enabled; disabled pairs belong to the port
  a_fault_forces_off: assert property (s_fault_seen |=>
      ((st.pin_out ^ pol) & st.pin_oe & {6{pair_on == 6'h3f}}) == 6'h00)
    else $error("Fault did not drive pins inactive");
  // A disabled input never raises the status bit
  a_disabled_fault_idle: assert property (
      !st.cfg_en && !st.fault_stat |=> !st.fault_stat)
    else $error("Disabled fault input acted");
  // With the input disabled only a breakpoint may start blocking
  a_disabled_no_block: assert property (
      !st.cfg_en && !brk_active && !st.fault_block |=> !st.fault_block)
    else $error("Disabled fault input blocked the pins");
  // Latched status leaves only through a register write
  a_latched_holds: assert property (
      st.fault_stat && !st.cfg_mode && !wr_acc |=> st.fault_stat)
    else $error("Latched status cleared without software");
  // Period starts do not release while latched status stands
  a_latched_waits: assert property (
      st.fault_block && !st.cfg_mode && st.cfg_en && st.fault_stat |=> st.fault_block)
    else $error("Latched fault released before status clear");
  // Cycle mode status clears itself at the first period start with the pin high
  a_cycle_clears: assert property (
      ((st.cfg_mode && !fault_active) and s_pin_high_at_start) |=> !st.fault_stat)
    else $error("Cycle mode status did not clear at period start");
  // Cycle mode pins come back at that same period start
  a_cycle_release: assert property (
      ((st.fault_block && st.cfg_mode && !brk_active) and s_pin_high_at_start)
      |=> !st.fault_block)
    else $error("Cycle mode pins not released at period start");
  // Status follows the enabled fault one cycle later
  a_status_sets: assert property (s_fault_seen |=> st.fault_stat)
    else $error("Status not set by fault");
  // Breakpoint blocks as a pin fault does, but leaves the status bit alone
  a_brk_forces: assert property (brk_active |=> st.fault_block)
    else $error("Breakpoint fault not blocking");
  // Locked active words stay put however the buffers move
  a_lock_holds: assert property (
      st.lockout && $stable(st.lockout) |=> $stable(st.act_word))
    else $error("Active words moved under lockout");
  // All five words land together one cycle after the unlock
  a_unlock_loads: assert property (
      $fell(st.lockout) |=> st.act_word == $past(st.buf_word))
    else $error("Unlock did not load all buffers");
  // Strap cycle excluded: the state still holds its reset image there
  a_port_passes: assert property (
      st.strap_done && !pair_on[0] |=> st.pin_oe[0] == $past(pin_direction_latch[0]))
    else $error("Port control lost on disabled pair");
  // Field 1xx hands every pin to the PWM side
  a_all_pins_driven: assert property (st.pin_en[2] |=> &st.pin_oe)
    else $error("Enabled pins not all driven");
  // High-side pin is the raw drive with its polarity applied last
  a_polarity_last: assert property (pair_on[1] && !force_off |=>
      st.pin_out[1] == ($past(pwm_raw[1]) ^ $past(high_side_polarity)))
    else $error("High-side polarity wrong");
  // Strap decides the enable field in the first cycle after reset
  a_strap_load: assert property (!st.strap_done |=> st.pin_en ==
      ($past(reset_pin_function_select) ? `PWMOFL_PIN_EN_OFF : `PWMOFL_PIN_EN_ALL))
    else $error("Reset strap not applied");
  // Stages two and three agreeing move the filtered fault level one cycle later
  a_sync_asserts: assert property (s_sync_low |=> st.fault_lvl)
    else $error("Filtered fault level did not follow the pin");
  a_sync_releases: assert property (s_sync_high |=> !st.fault_lvl)
    else $error("Filtered fault level did not release");
  // A pin fault blocks on its own; no register write takes part
  a_fault_blocks: assert property (s_fault_seen |=> st.fault_block)
    else $error("Fault did not block the pins");

endmodule

`default_nettype wire

// ### core/pwmofl_map.svh
// Register map, field positions, reset values and codes for the PWM output stage
`ifndef PWMOFL_MAP_SVH
`define PWMOFL_MAP_SVH

// Byte addresses of the APB registers
`define PWMOFL_OFS_FCFG     8'h00
`define PWMOFL_OFS_CTRL0    8'h04
`define PWMOFL_OFS_CTRL1    8'h08
`define PWMOFL_OFS_STATE    8'h0c
`define PWMOFL_OFS_DUTY0    8'h10
`define PWMOFL_OFS_PERIOD   8'h20
`define PWMOFL_OFS_IRQ_ST   8'h24
`define PWMOFL_OFS_IRQ_MASK 8'h28

// Fault configuration bits
`define PWMOFL_FCFG_EN      0
`define PWMOFL_FCFG_MODE    1
`define PWMOFL_FCFG_STAT    2
`define PWMOFL_FCFG_BRK     7

// Control register fields
`define PWMOFL_CTRL0_EN_LSB 4
`define PWMOFL_CTRL0_EN_MSB 6
`define PWMOFL_CTRL1_LOCK   1

// Reset values
`define PWMOFL_PIN_EN_OFF   3'h0
`define PWMOFL_PIN_EN_ALL   3'h4
`define PWMOFL_FCFG_RST     8'h00
`define PWMOFL_SYNC_IDLE    3'h7

// Buffered word slots: four duty words then the period word
`define PWMOFL_NUM_BUF      5
`define PWMOFL_BUF_W        12
`define PWMOFL_PERIOD_SLOT  3'h4

// Interrupt status bits
`define PWMOFL_IRQ_FAULT    0
`define PWMOFL_IRQ_BRK      1

`endif

// ### core/pwmofl_pkg.sv
// Types shared by the PWM output stage
package pwmofl_pkg;

  // Whole state of the output stage, registered in one process
  typedef struct packed {
    logic [2:0]       fsync;       // Fault pin synchroniser chain
    logic             fault_lvl;   // Filtered fault level, 1 = asserted
    logic             cfg_brk;     // Breakpoint acts as fault
    logic             cfg_mode;    // 0 latched, 1 cycle-by-cycle
    logic             cfg_en;      // Fault input enabled
    logic             fault_stat;  // Sticky fault status
    logic             fault_block; // Outputs held inactive to period start
    logic [2:0]       pin_en;      // Pin pair enable field
    logic             strap_done;  // Reset strap already applied
    logic             lockout;     // Update lockout
    logic [4:0][11:0] buf_word;    // Software buffers
    logic [4:0][11:0] act_word;    // Active compare values
    logic [1:0]       irq_st;      // Sticky interrupt status
    logic [1:0]       irq_mask;    // Interrupt mask
    logic             irq;         // Registered interrupt level
    logic             fault_prev;  // Edge detect for fault event
    logic             brk_prev;    // Edge detect for breakpoint event
    logic [5:0]       pin_out;     // Pin output levels
    logic [5:0]       pin_oe;      // Pin output enables
    logic [31:0]      prdata;      // Read data captured at setup
  } pwmofl_state_t;

endpackage

// ### verif/pwmofl_gate_model.sv
// Far-side model: wire-ORed fault sources and the power switch gates
`timescale 1ns/1ps
`default_nettype none

module pwmofl_gate_model
(
  input  wire logic [5:0] pin_out,            // Pin levels from the block
  input  wire logic [5:0] pin_oe,             // Pin drive enables
  input  wire logic       high_side_polarity, // Odd pins active low
  input  wire logic       low_side_polarity,  // Even pins active low
  input  wire logic [1:0] fault_req,          // Sources pulling the line
  output logic            fault_in_n,         // Shared fault line
  output logic [5:0]      gate_on             // Switch conducting
);
  // Open-drain sources on a pulled-up line: any one pulls it low
  assign fault_in_n = ~|fault_req;
  // Undriven pin falls to the gate pull-down, so that switch is off
  assign gate_on = pin_oe & (pin_out ^ {3{high_side_polarity, low_side_polarity}});
endmodule

`default_nettype wire

// ### verif/pwm_output_fault_lockout_test.sv
// Testbench for the PWM output stage
`include "pwmofl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_output_fault_lockout_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;          // q: last read word
  logic        e;                          // Last error flag
  logic [5:0]  pwm_raw, port_latch, pin_direction_latch, pin_out, pin_oe, gate_on;
  logic        period_start, fault_in_n, breakpoint;
  logic        high_side_polarity, low_side_polarity, reset_pin_function_select;
  logic [47:0] active_duty;
  logic [11:0] active_period;
  logic [1:0]  fault_req;                  // Fault sources
  int          mismatches, samples_checked;
  int          cycles = 0;                 // Hang guard

  pwmofl_top dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pwm_raw, .period_start, .fault_in_n, .breakpoint,
    .high_side_polarity, .low_side_polarity, .reset_pin_function_select,
    .port_latch, .pin_direction_latch, .pin_out, .pin_oe, .active_duty,
    .active_period, .irq
  );

  pwmofl_gate_model gates
  (
    .pin_out, .pin_oe, .high_side_polarity, .low_side_polarity,
    .fault_req, .fault_in_n, .gate_on
  );

  // 25 MHz clock
  always #20 pclk = ~pclk;

  // Verdict in one place
  task report_and_stop;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Ceiling far above the few hundred cycles needed
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop;
    end
  end

  task chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task chk_pins(input logic [5:0] g, input logic [5:0] x, input string m);
    chk_word({26'h0, g}, {26'h0, x}, m);
  endtask

  // One APB transfer; waits on pready, no fixed latency assumed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let registered outputs settle before looking
  task idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task pulse;
    @(posedge pclk);
    period_start <= 1'b1;
    @(posedge pclk);
    period_start <= 1'b0;
  endtask

  // Inactive level of every pin
  function automatic logic [5:0] pol;
    return {3{high_side_polarity, low_side_polarity}};
  endfunction

  task t_reset;
    apb(0, `PWMOFL_OFS_CTRL0, 32'h0);
    chk_word(q, 32'h0, "enable field");
    apb(0, `PWMOFL_OFS_FCFG, 32'h0);
    chk_word(q, 32'h0, "fault config");
    idle(1);
    chk_pins(pin_oe, pin_direction_latch, "port drive");
    chk_pins(pin_out & pin_direction_latch, port_latch & pin_direction_latch, "port");
    // Strap programmed low, then a mid-run reset
    @(posedge pclk);
    reset_pin_function_select <= 1'b0;
    presetn <= 1'b0;
    idle(2);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `PWMOFL_OFS_CTRL0, 32'h0);
    chk_word(q, 32'h40, "enable 100");
    chk_pins(pin_oe, 6'h3f, "all driven");
    chk_pins(pin_out, pwm_raw, "active high");
    chk_pins(gate_on, pwm_raw, "gates");
  endtask

  task t_polarity;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      {high_side_polarity, low_side_polarity} <= 2'(i);
      idle(3);
      chk_pins(pin_out, pwm_raw ^ pol(), "polarity");
    end
    // High side active low makes the inactive level uneven
    @(posedge pclk);
    {high_side_polarity, low_side_polarity} <= 2'b10;
  endtask

  task t_latched;
    apb(1, `PWMOFL_OFS_IRQ_MASK, 32'h1);
    apb(1, `PWMOFL_OFS_FCFG, 32'h1);
    fault_req <= 2'b01;
    idle(6);
    chk_pins(pin_out, pol(), "fault level");
    chk_pins(gate_on, 6'h0, "switches off");
    chk_word({31'h0, irq}, 32'h1, "irq on");
    @(posedge pclk);
    fault_req <= 2'b00;
    pulse;
    idle(6);
    apb(0, `PWMOFL_OFS_FCFG, 32'h0);
    chk_word(q, 32'h5, "status kept");
    chk_pins(pin_out, pol(), "latched");
    apb(1, `PWMOFL_OFS_FCFG, 32'h1);
    idle(3);
    chk_pins(pin_out, pol(), "waits period");
    pulse;
    idle(3);
    chk_pins(pin_out, pwm_raw ^ pol(), "resumed");
    apb(1, `PWMOFL_OFS_IRQ_ST, 32'h1);
    idle(2);
    chk_word({31'h0, irq}, 32'h0, "irq off");
  endtask

  task t_cycle;
    apb(1, `PWMOFL_OFS_IRQ_MASK, 32'h0);
    apb(1, `PWMOFL_OFS_FCFG, 32'h3);
    fault_req <= 2'b10;
    idle(6);
    chk_word({31'h0, irq}, 32'h0, "masked irq");
    pulse;
    idle(3);
    chk_pins(pin_out, pol(), "pin low holds");
    @(posedge pclk);
    fault_req <= 2'b00;
    apb(0, `PWMOFL_OFS_FCFG, 32'h0);
    chk_word(q, 32'h7, "status to period");
    pulse;
    idle(3);
    apb(0, `PWMOFL_OFS_FCFG, 32'h0);
    chk_word(q, 32'h3, "self cleared");
    chk_pins(pin_out, pwm_raw ^ pol(), "resumed");
    apb(1, `PWMOFL_OFS_IRQ_ST, 32'h3);
  endtask

  task t_off_and_break;
    apb(1, `PWMOFL_OFS_FCFG, 32'h80);
    fault_req <= 2'b11;
    idle(6);
    chk_pins(pin_out, pwm_raw ^ pol(), "fault ignored");
    @(posedge pclk);
    breakpoint <= 1'b1;
    idle(3);
    chk_pins(pin_out, pol(), "break fault");
    apb(0, `PWMOFL_OFS_IRQ_ST, 32'h0);
    chk_word(q, 32'h2, "break event");
    @(posedge pclk);
    breakpoint <= 1'b0;
    fault_req <= 2'b00;
    pulse;
    idle(3);
    chk_pins(pin_out, pwm_raw ^ pol(), "break over");
    apb(1, `PWMOFL_OFS_FCFG, 32'h0);
    breakpoint <= 1'b1;
    idle(3);
    chk_pins(pin_out, pwm_raw ^ pol(), "break ignored");
    @(posedge pclk);
    breakpoint <= 1'b0;
  endtask

  task t_lockout;
    apb(1, `PWMOFL_OFS_DUTY0, 32'h123);
    apb(1, `PWMOFL_OFS_PERIOD, 32'h111);
    apb(1, `PWMOFL_OFS_CTRL1, 32'h2);
    for (int i = 0; i < 4; i++)
      apb(1, `PWMOFL_OFS_DUTY0 + 8'(4 * i), 32'ha00 + 32'(i));
    apb(1, `PWMOFL_OFS_PERIOD, 32'hbcd);
    idle(2);
    chk_word({20'h0, active_duty[11:0]}, 32'h123, "duty held");
    chk_word({20'h0, active_period}, 32'h111, "period held");
    apb(1, `PWMOFL_OFS_CTRL1, 32'h0);
    idle(2);
    for (int i = 0; i < 4; i++)
      chk_word({20'h0, active_duty[12*i +: 12]}, 32'ha00 + 32'(i), "duty");
    chk_word({20'h0, active_period}, 32'hbcd, "period");
    apb(0, 8'h30, 32'h0);
    chk_word({e, q[30:0]}, 32'h80000000, "unmapped");
  endtask

  // Main sequence
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pwm_raw = 6'h2d;
    period_start = 0;
    breakpoint = 0;
    high_side_polarity = 0;
    low_side_polarity = 0;
    reset_pin_function_select = 1;
    port_latch = 6'h05;
    pin_direction_latch = 6'h0f;
    fault_req = 0;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_polarity;
    t_latched;
    t_cycle;
    t_off_and_break;
    t_lockout;
    report_and_stop;
  end
endmodule

`default_nettype wire
